// File: rtl/tmr_pkg.sv
// Package: register map, field positions and state types of the timer
package tmr_pkg;
    // ------------------------------------------------------------
    // Register addresses
    // ------------------------------------------------------------
    localparam logic [4:0] ADDR_CTRL_A = 5'h00;
    localparam logic [4:0] ADDR_CTRL_B = 5'h01;
    localparam logic [4:0] ADDR_FORCE = 5'h02;
    localparam logic [4:0] ADDR_MASK = 5'h03;
    localparam logic [4:0] ADDR_FLAGS = 5'h04;
    localparam logic [4:0] ADDR_CNT_L = 5'h06;
    localparam logic [4:0] ADDR_CNT_H = 5'h07;
    localparam logic [4:0] ADDR_ICR_L = 5'h08;
    localparam logic [4:0] ADDR_ICR_H = 5'h09;
    localparam logic [4:0] ADDR_OCR_L = 5'h0A;
    localparam logic [4:0] ADDR_CAP_SRC = 5'h10;

    // ------------------------------------------------------------
    // Field positions and masks
    // ------------------------------------------------------------
    localparam int BIT_NOISE_EN = 7;
    localparam int BIT_EDGE_SEL = 6;
    localparam int BIT_FORCE_A = 7;
    localparam int BIT_CAP = 5;
    localparam int BIT_OVF = 0;
    localparam logic [7:0] CTRL_B_MASK = 8'hDF;
    localparam logic [7:0] FORCE_MASK = 8'hE0;
    localparam logic [7:0] IRQ_MASK = 8'h2F;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [15:0] RESET_WORD = 16'h0000;

    // ------------------------------------------------------------
    // Clock select codes and prescaler taps
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam logic [9:0] PRE_8 = 10'h007;
    localparam logic [9:0] PRE_64 = 10'h03F;
    localparam logic [9:0] PRE_256 = 10'h0FF;
    localparam logic [9:0] PRE_1024 = 10'h3FF;
    localparam int FILTER_LEN = 4;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [4:0] addr;
        logic [7:0] wrData;
        logic wrStrobe;
        logic rdStrobe;
    } tmr_bus_t;

    typedef struct packed {
        logic [FILTER_LEN-2:0] hist;
        logic filt;
        logic prev;
    } tmr_filt_t;

    typedef struct packed {
        logic [7:0] ctrlA;
        logic [7:0] ctrlB;
        logic [7:0] mask;
        logic [7:0] flags;
        logic capSrc;
        logic [15:0] cnt;
        logic [15:0] icr;
        logic [2:0][15:0] ocr;
        logic [7:0] temp;
        logic [9:0] pre;
        logic extPrev;
        logic blk;
        logic [2:0] outPin;
        logic [7:0] rdData;
    } tmr_state_t;
endpackage

// File: rtl/tmr_capture_filter.sv
// Capture input noise filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module tmr_capture_filter
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic rstN,
    input wire logic pinIn,
    input wire logic filterEn,
    input wire logic edgeSel,
    output logic trig
);
    tmr_filt_t s_reg;
    tmr_filt_t s_next;
    logic [FILTER_LEN-1:0] window;

    always_comb begin
        s_next = s_reg;
        window = {s_reg.hist, pinIn};
        s_next.hist = window[FILTER_LEN-2:0];
        s_next.prev = s_reg.filt;
        if (!filterEn) begin
            s_next.filt = pinIn;
        end else if (&window) begin
            s_next.filt = 1'b1;
        end else if (~|window) begin
            s_next.filt = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // Zero picks the falling edge, one the rising edge
    assign trig = edgeSel ? (s_reg.filt & ~s_reg.prev)
                          : (~s_reg.filt & s_reg.prev);

    filt_delay_a: assert property (@(posedge clk) disable iff (!rstN)
        $past(filterEn) && $rose(s_reg.filt) |->
        $past(pinIn, 1) && $past(pinIn, 2) && $past(pinIn, 3)
        && $past(pinIn, 4))
        else $error("filtered input rose without four high samples");
endmodule
`default_nettype wire

// File: rtl/tmr_core.sv
// Sixteen-bit timer: registers, prescaler, counter, compare and capture
//
// Local design decisions: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
module tmr_core
    import tmr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire tmr_bus_t bus,
    output logic [7:0] rdData,
    input wire logic capturePin,
    input wire logic compEvent,
    input wire logic externalCountPin,
    input wire logic globalIntEnable,
    input wire logic [7:0] intAck,
    output logic [7:0] irqReq,
    output logic [2:0] comparePin
);
    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    logic [1:0] rstSync_reg;
    logic rstN;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstSync_reg <= 2'h0;
        end else begin
            rstSync_reg <= {rstSync_reg[0], 1'b1};
        end
    end
    assign rstN = rstSync_reg[1];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstN);

    // ------------------------------------------------------------
    // Decoding helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] topOf(input logic [3:0] wgm,
                                          input logic [15:0] ocrA,
                                          input logic [15:0] icr);
        logic [15:0] t;
        t = 16'hFFFF;
        unique case (wgm)
            4'h1, 4'h5: t = 16'h00FF;
            4'h2, 4'h6: t = 16'h01FF;
            4'h3, 4'h7: t = 16'h03FF;
            4'h4, 4'h9, 4'hB, 4'hF: t = ocrA;
            4'h8, 4'hA, 4'hC, 4'hE: t = icr;
            default: t = 16'hFFFF;
        endcase
        return t;
    endfunction

    function automatic logic isPwm(input logic [3:0] wgm);
        return !(wgm == 4'h0 || wgm == 4'h4 || wgm == 4'hC);
    endfunction

    function automatic logic usesIcrTop(input logic [3:0] wgm);
        return wgm == 4'h8 || wgm == 4'hA || wgm == 4'hC
            || wgm == 4'hE;
    endfunction

    // Non-PWM compare actions: toggle, clear, set
    function automatic logic applyAction(input logic [1:0] act,
                                         input logic cur);
        logic r;
        r = cur;
        unique case (act)
            2'h1: r = ~cur;
            2'h2: r = 1'b0;
            2'h3: r = 1'b1;
            default: r = cur;
        endcase
        return r;
    endfunction

    // ------------------------------------------------------------
    // Capture front end
    // ------------------------------------------------------------
    tmr_state_t s_reg;
    tmr_state_t s_next;
    logic capTrig;
    logic capEvt;
    logic [3:0] wgm;
    logic [2:0] cs;
    logic [15:0] top;
    logic tick;
    logic [2:0] match;
    logic [2:0] forceHit;
    logic wrCnt;
    logic [7:0] setFlags;
    logic [7:0] clrFlags;
    logic [2:0] slot;

    tmr_capture_filter u_filter (
        .clk(clk),
        .rstN(rstN),
        .pinIn(s_reg.capSrc ? compEvent : capturePin),
        .filterEn(s_reg.ctrlB[BIT_NOISE_EN]),
        .edgeSel(s_reg.ctrlB[BIT_EDGE_SEL]),
        .trig(capTrig)
    );

    assign wgm = {s_reg.ctrlB[4:3], s_reg.ctrlA[1:0]};
    assign cs = s_reg.ctrlB[2:0];
    assign top = topOf(wgm, s_reg.ocr[0], s_reg.icr);
    // Capture pin is cut off while its register sets the top
    assign capEvt = capTrig && !usesIcrTop(wgm);

    // ------------------------------------------------------------
    // Timer clock select
    // ------------------------------------------------------------
    always_comb begin
        unique case (cs)
            CS_STOP: tick = 1'b0;
            CS_DIV1: tick = 1'b1;
            CS_DIV8: tick = (s_reg.pre[2:0] == PRE_8[2:0]);
            CS_DIV64: tick = (s_reg.pre[5:0] == PRE_64[5:0]);
            CS_DIV256: tick = (s_reg.pre[7:0] == PRE_256[7:0]);
            CS_DIV1024: tick = (s_reg.pre == PRE_1024);
            // Pin is read as a plain input whatever drives it
            CS_EXT_FALL: tick = s_reg.extPrev && !externalCountPin;
            CS_EXT_RISE: tick = !s_reg.extPrev && externalCountPin;
        endcase
    end

    // ------------------------------------------------------------
    // Compare, force and write decode
    // ------------------------------------------------------------
    assign slot = 3'(bus.addr - ADDR_OCR_L);
    assign wrCnt = bus.wrStrobe && bus.addr == ADDR_CNT_L;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_chan
            // Blocked on the timer clock after a counter write
            assign match[gi] = tick && !s_reg.blk
                && s_reg.cnt == s_reg.ocr[gi];
            assign forceHit[gi] = bus.wrStrobe && bus.addr == ADDR_FORCE
                && bus.wrData[BIT_FORCE_A-gi] && !isPwm(wgm);
        end
    endgenerate

    always_comb begin
        setFlags = 8'h00;
        setFlags[3:1] = match;
        setFlags[BIT_CAP] = capEvt;
        setFlags[BIT_OVF] = tick && s_reg.cnt == top;
        clrFlags = intAck;
        if (bus.wrStrobe && bus.addr == ADDR_FLAGS) begin
            clrFlags = clrFlags | bus.wrData;
        end
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        s_next = s_reg;
        s_next.pre = s_reg.pre + 10'h001;
        s_next.extPrev = externalCountPin;
        s_next.rdData = 8'h00;
        // Set wins over a clear in the same cycle
        s_next.flags = ((s_reg.flags & ~clrFlags) | setFlags)
            & IRQ_MASK;
        if (tick) begin
            s_next.blk = 1'b0;
            s_next.cnt = (s_reg.cnt == top) ? 16'h0000
                : s_reg.cnt + 16'h0001;
        end
        if (capEvt) begin
            s_next.icr = s_reg.cnt;
        end
        for (int i = 0; i < 3; i++) begin
            if (match[i] || forceHit[i]) begin
                s_next.outPin[i] = applyAction(
                    s_reg.ctrlA[7-2*i -: 2], s_reg.outPin[i]);
            end
        end
        if (bus.wrStrobe) begin
            unique case (bus.addr)
                ADDR_CTRL_A: s_next.ctrlA = bus.wrData;
                ADDR_CTRL_B: s_next.ctrlB = bus.wrData
                    & CTRL_B_MASK;
                ADDR_MASK: s_next.mask = bus.wrData
                    & IRQ_MASK;
                ADDR_CAP_SRC: s_next.capSrc = bus.wrData[0];
                ADDR_CNT_L: begin
                    s_next.cnt = {s_reg.temp, bus.wrData};
                    s_next.blk = 1'b1;
                end
                ADDR_ICR_L: s_next.icr = {s_reg.temp, bus.wrData};
                ADDR_OCR_L, ADDR_OCR_L + 5'h02, ADDR_OCR_L + 5'h04:
                    s_next.ocr[slot[2:1]] = {s_reg.temp,
                                             bus.wrData};
                ADDR_CNT_H, ADDR_ICR_H, ADDR_OCR_L + 5'h01,
                ADDR_OCR_L + 5'h03, ADDR_OCR_L + 5'h05:
                    s_next.temp = bus.wrData;
                default: ;
            endcase
        end
        if (bus.rdStrobe) begin
            unique case (bus.addr)
                ADDR_CTRL_A: s_next.rdData = s_reg.ctrlA;
                ADDR_CTRL_B: s_next.rdData = s_reg.ctrlB;
                ADDR_FORCE: s_next.rdData = 8'h00;
                ADDR_MASK: s_next.rdData = s_reg.mask;
                ADDR_FLAGS: s_next.rdData = s_reg.flags;
                ADDR_CAP_SRC: s_next.rdData = {7'h00, s_reg.capSrc};
                ADDR_CNT_L: begin
                    s_next.rdData = s_reg.cnt[7:0];
                    s_next.temp = s_reg.cnt[15:8];
                end
                ADDR_ICR_L: begin
                    s_next.rdData = s_reg.icr[7:0];
                    s_next.temp = s_reg.icr[15:8];
                end
                ADDR_OCR_L, ADDR_OCR_L + 5'h02, ADDR_OCR_L + 5'h04: begin
                    s_next.rdData = s_reg.ocr[slot[2:1]][7:0];
                    s_next.temp = s_reg.ocr[slot[2:1]][15:8];
                end
                ADDR_CNT_H, ADDR_ICR_H, ADDR_OCR_L + 5'h01,
                ADDR_OCR_L + 5'h03, ADDR_OCR_L + 5'h05:
                    s_next.rdData = s_reg.temp;
                default: s_next.rdData = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdData = s_reg.rdData;
    assign comparePin = s_reg.outPin;
    assign irqReq = s_reg.flags & s_reg.mask
        & {8{globalIntEnable}};

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    cap_load_a: assert property (
        capEvt |=> s_reg.icr == $past(s_reg.cnt)
        && s_reg.flags[BIT_CAP])
        else $error("capture did not load counter and flag");

    cap_off_a: assert property (
        usesIcrTop(wgm) && capTrig && !bus.wrStrobe |=>
        $stable(s_reg.icr) && !$rose(s_reg.flags[BIT_CAP]))
        else $error("capture fired while capture register is top");

    cnt_latch_a: assert property (
        bus.rdStrobe && bus.addr == ADDR_CNT_L |=>
        s_reg.temp == $past(s_reg.cnt[15:8]))
        else $error("low counter read did not latch high byte");

    match_flag_a: assert property (
        match[1] |=> s_reg.flags[2])
        else $error("compare B match did not set its flag");

    force_read_a: assert property (
        bus.rdStrobe && bus.addr == ADDR_FORCE |=> rdData == 8'h00)
        else $error("force register read not zero");

    force_noflag_a: assert property (
        forceHit[0] && !tick && !intAck[1] |=>
        s_reg.flags[1] == $past(s_reg.flags[1])
        && s_reg.cnt == $past(s_reg.cnt))
        else $error("force strobe changed flag or counter");

    force_pin_a: assert property (
        forceHit[0] && s_reg.ctrlA[7:6] == 2'h1 && !match[0] |=>
        comparePin[0] != $past(comparePin[0]))
        else $error("forced toggle did not toggle pin");

    cnt_block_a: assert property (
        wrCnt |=> !match[0] && !match[1] && !match[2]
        until_with tick)
        else $error("match after counter write not blocked");

    blk_bound_a: assert property (
        s_reg.blk && tick && !wrCnt |=> !s_reg.blk)
        else $error("match block held too long");

    flag_clear_a: assert property (
        bus.wrStrobe && bus.addr == ADDR_FLAGS && bus.wrData[BIT_CAP]
        && !capEvt |=> !s_reg.flags[BIT_CAP])
        else $error("written one did not clear capture flag");

    irq_gate_a: assert property (
        !globalIntEnable |-> irqReq == 8'h00)
        else $error("request raised without global enable");

    stopped_a: assert property (
        cs == CS_STOP && !bus.wrStrobe |=> $stable(s_reg.cnt))
        else $error("counter moved while stopped");

    ext_rise_a: assert property (
        cs == CS_EXT_RISE && $rose(externalCountPin) && !bus.wrStrobe
        && s_reg.cnt != top |=> s_reg.cnt == $past(s_reg.cnt) + 16'h1)
        else $error("rising external edge not counted");

    ocr_commit_a: assert property (
        bus.wrStrobe && bus.addr == ADDR_OCR_L |=>
        s_reg.ocr[0] == {$past(s_reg.temp), $past(bus.wrData)})
        else $error("low byte write did not commit word");

    div8_a: assert property (
        cs == CS_DIV8 && tick |=> !tick [*7])
        else $error("divide by eight ticked early");
endmodule
`default_nettype wire

// File: verif/tmr_pin_model.sv
// Pin-side partner model: capture input and external count pin
`timescale 1ns/1ps
`default_nettype none
module tmr_pin_model (
    input wire logic clk,
    output var logic capturePin,
    output var logic externalCountPin
);
    initial begin
        capturePin = 1'b0;
        externalCountPin = 1'b0;
    end

    // Holds the capture pin at one level for n clocks
    task automatic cap(input logic level, input int n);
        @(posedge clk);
        capturePin <= level;
        repeat (n - 1) @(posedge clk);
    endtask

    // Toggles the count pin as software would on a port set as output
    task automatic count_pulses(input int n);
        repeat (n) begin
            @(posedge clk);
            externalCountPin <= 1'b1;
            repeat (6) @(posedge clk);
            externalCountPin <= 1'b0;
            repeat (5) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// File: verif/tb.sv
// Testbench for the timer core: registers, counting, compare, capture
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tmr_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    tmr_bus_t bus = '0;
    logic [7:0] rdData;
    logic capturePin;
    logic externalCountPin;
    logic globalIntEnable = 1'b0;
    logic compEvent = 1'b0;
    logic [7:0] intAck = 8'h00;
    logic [7:0] irqReq;
    logic [2:0] comparePin;
    int error_cnt = 0;
    int total_checks = 0;
    int cycles = 0;
    logic [15:0] w;
    int divs [5] = '{1, 8, 64, 256, 1024};

    always #2.5 clk = ~clk;

    tmr_core i_tmr_core (
        .clk, .rst_n, .bus, .rdData, .capturePin,
        .compEvent, .externalCountPin, .globalIntEnable,
        .intAck, .irqReq, .comparePin
    );

    tmr_pin_model i_tmr_pin_model (.clk, .capturePin, .externalCountPin);

    // ------------------------------------------------------------
    // Reporting
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Sized for the five prescaler runs plus margin
    always @(posedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            error_cnt++;
            $display("MISMATCH at %0t: run did not finish", $time);
            complete_run();
        end
    end

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic chkr(input logic [15:0] got, input int lo, input int hi);
        total_checks++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            error_cnt++;
            $display("MISMATCH at %0t: %h not in %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk);
        bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask

    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk);
        bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk);
        bus <= '0;
        #1 d = rdData;
    endtask

    task automatic rc(input logic [4:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk({8'h00, d}, {8'h00, exp});
    endtask

    // High byte goes first into the shared latch; low byte commits
    task automatic wr16(input logic [4:0] a, input logic [15:0] v);
        wr(a + 5'h01, v[15:8]);
        wr(a, v[7:0]);
    endtask

    task automatic rd16(input logic [4:0] a, output logic [15:0] v);
        logic [7:0] lo;
        logic [7:0] hi;
        rd(a, lo);
        rd(a + 5'h01, hi);
        v = {hi, lo};
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic chk_pin(input logic [2:0] exp);
        settle();
        chk({13'h0000, comparePin}, {13'h0000, exp});
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rc(ADDR_CTRL_B, 8'h00);
        rc(ADDR_FORCE, 8'h00);
        rc(ADDR_MASK, 8'h00);
        rd16(ADDR_OCR_L, w);
        chk(w, 16'h0000);
        rc(5'h1F, 8'h00);
        wr(ADDR_MASK, 8'hFF);
        rc(ADDR_MASK, IRQ_MASK);
        wr(ADDR_FORCE, 8'h1F);
        rc(ADDR_FORCE, 8'h00);
        wr16(ADDR_CNT_L, 16'h1234);
        rd16(ADDR_CNT_L, w);
        chk(w, 16'h1234);
        wr(ADDR_CNT_H, 8'h56);
        wr(ADDR_OCR_L, 8'h78);
        rd16(ADDR_OCR_L, w);
        chk(w, 16'h5678);
        rd16(ADDR_CNT_L, w);
        chk(w, 16'h1234);
        for (int i = 0; i < 5; i++) begin
            wr16(ADDR_CNT_L, 16'h0000);
            wr(ADDR_CTRL_B, 8'(i + 1));
            repeat (4094) @(posedge clk);
            wr(ADDR_CTRL_B, 8'h00);
            rd16(ADDR_CNT_L, w);
            chkr(w, 4096 / divs[i] - (divs[i] == 1 ? 3 : 1),
                 4096 / divs[i] + (divs[i] == 1 ? 3 : 1));
        end
        repeat (50) @(posedge clk);
        rd16(ADDR_CNT_L, w);
        chkr(w, 3, 5);
        for (int i = 0; i < 2; i++) begin
            wr16(ADDR_CNT_L, 16'h0000);
            wr(ADDR_CTRL_B, {5'h00, CS_EXT_FALL | 3'(i)});
            i_tmr_pin_model.count_pulses(3);
            wr(ADDR_CTRL_B, 8'h00);
            rd16(ADDR_CNT_L, w);
            chk(w, 16'h0003);
        end
        // Compare match, flag, request gating and acknowledge
        wr(ADDR_CTRL_A, 8'h54);
        wr16(ADDR_OCR_L, 16'h0005);
        wr16(ADDR_CNT_L, 16'h0000);
        wr(ADDR_FLAGS, 8'hFF);
        rc(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        globalIntEnable <= 1'b1;
        repeat (30) @(posedge clk);
        wr(ADDR_CTRL_B, 8'h00);
        rc(ADDR_FLAGS, 8'h02);
        chk({8'h00, irqReq}, 16'h0002);
        chk({13'h0000, comparePin}, 16'h0001);
        wr(ADDR_MASK, 8'h20);
        settle();
        chk({8'h00, irqReq}, 16'h0000);
        wr(ADDR_MASK, 8'h2F);
        globalIntEnable <= 1'b0;
        settle();
        chk({8'h00, irqReq}, 16'h0000);
        @(posedge clk);
        intAck <= 8'h02;
        @(posedge clk);
        intAck <= 8'h00;
        rc(ADDR_FLAGS, 8'h00);
        // Counter written to the compare value: first match suppressed
        wr16(ADDR_CNT_L, 16'h0005);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        repeat (10) @(posedge clk);
        wr(ADDR_CTRL_B, 8'h00);
        rc(ADDR_FLAGS, 8'h00);
        chk_pin(3'b001);
        // Forced compare strobes
        wr(ADDR_FORCE, 8'hE0);
        chk_pin(3'b110);
        rc(ADDR_FORCE, 8'h00);
        rc(ADDR_FLAGS, 8'h00);
        wr(ADDR_CTRL_A, 8'h55);
        wr(ADDR_FORCE, 8'hE0);
        chk_pin(3'b110);
        wr(ADDR_CTRL_A, 8'h54);
        wr16(ADDR_CNT_L, 16'h0010);
        wr(ADDR_CTRL_B, 8'h08);
        wr(ADDR_FORCE, 8'h80);
        rd16(ADDR_CNT_L, w);
        chk(w, 16'h0010);
        rc(ADDR_FLAGS, 8'h00);
        // Capture on rising, then falling edge
        wr16(ADDR_CNT_L, 16'h00AB);
        wr(ADDR_CTRL_B, 8'h40);
        i_tmr_pin_model.cap(1'b1, 6);
        rc(ADDR_FLAGS, 8'h20);
        rd16(ADDR_ICR_L, w);
        chk(w, 16'h00AB);
        // Pin is brought low first so the falling select sees a rise before the fall
        i_tmr_pin_model.cap(1'b0, 8);
        wr(ADDR_FLAGS, 8'hFF);
        wr16(ADDR_CNT_L, 16'h00CD);
        wr(ADDR_CTRL_B, 8'h00);
        i_tmr_pin_model.cap(1'b1, 8);
        rc(ADDR_FLAGS, 8'h00);
        i_tmr_pin_model.cap(1'b0, 8);
        rc(ADDR_FLAGS, 8'h20);
        rd16(ADDR_ICR_L, w);
        chk(w, 16'h00CD);
        wr16(ADDR_ICR_L, 16'h9ABC);
        rd16(ADDR_ICR_L, w);
        chk(w, 16'h9ABC);
        // Noise filter: three equal samples are not enough
        wr(ADDR_FLAGS, 8'hFF);
        wr(ADDR_CTRL_B, 8'hC0);
        i_tmr_pin_model.cap(1'b1, 3);
        i_tmr_pin_model.cap(1'b0, 8);
        rc(ADDR_FLAGS, 8'h00);
        i_tmr_pin_model.cap(1'b1, 8);
        rc(ADDR_FLAGS, 8'h20);
        i_tmr_pin_model.cap(1'b0, 8);
        // Capture register as top: pin disconnected
        wr(ADDR_FLAGS, 8'hFF);
        wr16(ADDR_CNT_L, 16'h0001);
        wr(ADDR_CTRL_B, 8'h58);
        i_tmr_pin_model.cap(1'b1, 8);
        i_tmr_pin_model.cap(1'b0, 8);
        rc(ADDR_FLAGS, 8'h00);
        // Alternate capture source: pin ignored, comparator event taken
        wr(ADDR_CTRL_B, 8'h40);
        wr(ADDR_CAP_SRC, 8'h01);
        wr16(ADDR_CNT_L, 16'h0042);
        wr(ADDR_FLAGS, 8'hFF);
        i_tmr_pin_model.cap(1'b1, 8);
        rc(ADDR_FLAGS, 8'h00);
        @(posedge clk);
        compEvent <= 1'b1;
        repeat (4) @(posedge clk);
        rc(ADDR_FLAGS, 8'h20);
        rd16(ADDR_ICR_L, w);
        chk(w, 16'h0042);
        // Two ticks: wrap sets overflow, then zero matches B and C
        wr(ADDR_FLAGS, 8'hFF);
        wr16(ADDR_CNT_L, 16'hFFFF);
        wr(ADDR_CTRL_B, {5'h00, CS_DIV1});
        wr(ADDR_CTRL_B, 8'h00);
        rc(ADDR_FLAGS, 8'h0D);
        chk_pin(3'b001);
        complete_run();
    end
endmodule
`default_nettype wire
